/* rtl/pwo_top.sv */
// Behaviour
// (RULE1) Own 16-bit up timer on prescaled tick
// (RULE2) Standard: set on phase, clear on duty
// (RULE3) Standard: period match resets timer
// (RULE4) Set-on-match: phase sets, software clears
// (RULE5) Set-on-match ignores duty; period is ceiling
// (RULE6) Output bit write applies next tick
// (RULE7) Toggle: toggle at phase after period
// (RULE8) Toggle mode ignores output bit writes
// (RULE9) Center: count up to period, down
// (RULE10) Center: set at period-duty, clear +1
// (RULE11) Center mode ignores output bit writes
// (RULE12) Output bit readback synchronised to bus
// (RULE13) Own enable or global mirror enable
// (RULE14) Polarity inverts pin even when disabled
// (RULE15) Independent: run while enabled, wrap
// (RULE16) Sync start: hold until master offset
// (RULE17) One-shot: run one period per offset
// (RULE18) One-shot ignores offset while running
// (RULE19) Software avoids equal master/slave periods
// (RULE20) Counts buffered, loaded at period end
// (RULE21) Reset mode: master offset reloads 1
// (RULE22) Load arm loads at period, self-clears
// (RULE23) Four flags set on match rising edge
// (RULE24) Center offset match follows direction bit
// (RULE25) Offset match event driven to slaves
//
// The register offsets and the APB register port are this design's own decisions.
module pwo_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pwm_clk_tick,
    input wire logic master_offset_event,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pwm_out,
    output logic offset_event_out
);
    import pwo_pkg::*;

    // Control register fields
    logic en_ff; // Module enable
    logic glob_ff; // Global enable mirror
    logic pol_ff; // Polarity invert
    logic [1:0] mode_ff; // Waveform mode
    logic [1:0] ofm_ff; // Offset mode
    logic ofo_buf_ff; // Buffered offset direction
    logic [7:0] clksel_ff; // Clock select, stored only
    logic arm_ff; // Load arm bit
    logic [3:0] flag_ff; // Sticky match flags
    // Buffered counts written by software
    logic [15:0] ph_buf_ff, dc_buf_ff, pr_buf_ff, of_buf_ff;
    // Operating counts seen by comparators
    logic [15:0] ph_ff, dc_ff, pr_ff, of_ff;
    logic ofo_ff; // Operating offset direction
    // Timer and waveform state
    logic [15:0] tmr_ff; // Wave timer
    logic down_ff; // Center mode counting down
    logic run_ff; // Slave started
    logic out_ff; // Active-high wave level
    logic sw_pend_ff; // Pending software output write
    logic sw_val_ff; // Value of pending write
    logic tog_arm_ff; // Toggle armed by period event
    logic [3:0] match_d_ff; // Previous match levels
    logic out_rd; // Synchronised output readback

    // Bus decode
    logic wr_acc, rd_acc, active, tick, per_evt, ofs_in;
    logic ph_m, dc_m, pr_m, of_m, ctr_up_m, ctr_dn_m;
    logic [15:0] ctr_val;

    // Full equality test used by several comparators
    function automatic logic eq16(input logic [15:0] a,
                                  input logic [15:0] b);
        eq16 = (a == b);
    endfunction : eq16

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign active = en_ff || glob_ff; // RULE13
    assign tick = active && pwm_clk_tick; // RULE1
    assign ofs_in = master_offset_event;
    // Center-mode match points
    assign ctr_val = pr_ff - dc_ff; // RULE10
    assign ctr_up_m = !down_ff && eq16(tmr_ff, ctr_val);
    assign ctr_dn_m = down_ff && eq16(tmr_ff, ctr_val + 16'h0001);
    // Event comparators
    assign ph_m = eq16(tmr_ff, ph_ff);
    assign dc_m = eq16(tmr_ff, dc_ff);
    assign pr_m = eq16(tmr_ff, pr_ff);
    // Offset match honours direction only in center mode
    assign of_m = eq16(tmr_ff, of_ff) &&
        (mode_ff != MODE_CTR || down_ff == ofo_ff); // RULE24 RULE25
    // Period event: top in edge modes, bottom turn in center
    assign per_evt = tick && run_ff && ((mode_ff == MODE_CTR) ?
        (down_ff && eq16(tmr_ff, CNT_RST)) : pr_m); // RULE3

    // APB slave answers in the access cycle, no wait states
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
        end
    end

    // Read data captured in setup, held for the access
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata <= RD_NONE;
        end else if (rd_acc) begin
            case (paddr)
                OFS_CTRL: prdata <= {21'h0, ofo_buf_ff, ofm_ff,
                    en_ff, 1'b0, out_rd, pol_ff, mode_ff,
                    2'h0}; // RULE12
                OFS_PHASE: prdata <= {16'h0, ph_buf_ff};
                OFS_DUTY: prdata <= {16'h0, dc_buf_ff};
                OFS_PERIOD: prdata <= {16'h0, pr_buf_ff};
                OFS_OFFSET: prdata <= {16'h0, of_buf_ff};
                OFS_TIMER: prdata <= {16'h0, tmr_ff};
                OFS_CLKSEL: prdata <= {24'h0, clksel_ff};
                OFS_LOAD: prdata <= {31'h0, arm_ff};
                OFS_FLAGS: prdata <= {28'h0, flag_ff};
                OFS_GLOBAL: prdata <= {31'h0, glob_ff};
                default: prdata <= RD_NONE;
            endcase
        end
    end

    // Control fields written by software
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_ff <= 1'b0;
            pol_ff <= 1'b0;
            mode_ff <= MODE_STD;
            ofm_ff <= OFM_IND;
            ofo_buf_ff <= 1'b0;
            clksel_ff <= CLKSEL_RST;
            glob_ff <= 1'b0;
        end else if (wr_acc) begin
            if (paddr == OFS_CTRL) begin
                en_ff <= pwdata[CTL_EN];
                pol_ff <= pwdata[CTL_POL];
                mode_ff <= pwdata[CTL_MODE +: 2];
                ofm_ff <= pwdata[CTL_OFM +: 2];
                ofo_buf_ff <= pwdata[CTL_OFO];
            end
            if (paddr == OFS_CLKSEL) begin
                clksel_ff <= pwdata[7:0];
            end
            if (paddr == OFS_GLOBAL) begin
                glob_ff <= pwdata[0]; // RULE13
            end
        end
    end

    // Buffered count registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ph_buf_ff <= CNT_RST;
            dc_buf_ff <= CNT_RST;
            pr_buf_ff <= CNT_RST;
            of_buf_ff <= CNT_RST;
        end else if (wr_acc) begin
            case (paddr)
                OFS_PHASE: ph_buf_ff <= pwdata[15:0]; // RULE20
                OFS_DUTY: dc_buf_ff <= pwdata[15:0];
                OFS_PERIOD: pr_buf_ff <= pwdata[15:0];
                OFS_OFFSET: of_buf_ff <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Load arm: set by software, cleared by the load itself
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            arm_ff <= 1'b0;
        end else if (arm_ff && (per_evt || !active)) begin
            arm_ff <= 1'b0; // RULE22
        end else if (wr_acc && paddr == OFS_LOAD) begin
            arm_ff <= pwdata[LD_ARM];
        end
    end

    // Operating counts take buffers together at period end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ph_ff <= CNT_RST;
            dc_ff <= CNT_RST;
            pr_ff <= CNT_RST;
            of_ff <= CNT_RST;
            ofo_ff <= 1'b0;
        end else if (arm_ff && (per_evt || !active)) begin
            ph_ff <= ph_buf_ff; // RULE20 RULE22
            dc_ff <= dc_buf_ff;
            pr_ff <= pr_buf_ff;
            of_ff <= of_buf_ff;
            ofo_ff <= ofo_buf_ff;
        end
    end

    // Slave run state per offset mode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
        end else if (!active) begin
            run_ff <= 1'b0;
        end else begin
            case (ofm_ff)
                OFM_IND: run_ff <= 1'b1; // RULE15
                OFM_SYNC, OFM_RST: begin
                    if (ofs_in) begin
                        run_ff <= 1'b1; // RULE16 RULE21
                    end
                end
                OFM_ONE: begin
                    if (per_evt) begin
                        run_ff <= 1'b0; // RULE17
                    end else if (ofs_in) begin
                        run_ff <= 1'b1; // RULE18
                    end
                end
                default: run_ff <= 1'b0;
            endcase
        end
    end

    // Wave timer, up or up/down
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tmr_ff <= CNT_RST;
            down_ff <= 1'b0;
        end else if (!active) begin
            tmr_ff <= CNT_RST;
            down_ff <= 1'b0;
        end else if (ofm_ff == OFM_RST && run_ff && ofs_in) begin
            tmr_ff <= 16'h0001; // RULE21
            down_ff <= 1'b0;
        end else if (tick && run_ff) begin
            if (mode_ff == MODE_CTR) begin
                // Turn points held one tick: 2*(period+1) per cycle
                if (!down_ff && pr_m) begin
                    down_ff <= 1'b1; // RULE9
                end else if (down_ff && eq16(tmr_ff, CNT_RST)) begin
                    down_ff <= 1'b0;
                end else if (down_ff) begin
                    tmr_ff <= tmr_ff - 16'h0001;
                end else begin
                    tmr_ff <= tmr_ff + 16'h0001;
                end
            end else if (pr_m) begin
                tmr_ff <= CNT_RST; // RULE3 RULE5 RULE15
                down_ff <= 1'b0;
            end else begin
                tmr_ff <= tmr_ff + 16'h0001; // RULE1
            end
        end
    end

    // Software output write, held until next PWM tick
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sw_pend_ff <= 1'b0;
            sw_val_ff <= 1'b0;
        end else if (wr_acc && paddr == OFS_CTRL &&
                     mode_ff == MODE_SET) begin
            sw_pend_ff <= 1'b1; // RULE6
            sw_val_ff <= pwdata[CTL_OUT];
        end else if (tick || mode_ff != MODE_SET) begin
            sw_pend_ff <= 1'b0; // RULE8 RULE11
        end
    end

    // Waveform generator
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_ff <= 1'b0;
            tog_arm_ff <= 1'b0;
        end else if (!active) begin
            out_ff <= 1'b0; // RULE4
            tog_arm_ff <= 1'b0;
        end else if (tick && run_ff) begin
            case (mode_ff)
                MODE_STD: begin
                    if (dc_m) begin
                        out_ff <= 1'b0; // RULE2
                    end else if (ph_m) begin
                        out_ff <= 1'b1;
                    end
                end
                MODE_SET: begin
                    if (sw_pend_ff) begin
                        out_ff <= sw_val_ff; // RULE6
                    end else if (ph_m && tmr_ff <= pr_ff) begin
                        out_ff <= 1'b1; // RULE4 RULE5
                    end
                end
                MODE_TOG: begin
                    if (pr_m) begin
                        tog_arm_ff <= 1'b1;
                    end else if (ph_m && tog_arm_ff) begin
                        out_ff <= !out_ff; // RULE7
                        tog_arm_ff <= 1'b0;
                    end
                end
                MODE_CTR: begin
                    if (ctr_up_m) begin
                        out_ff <= 1'b1; // RULE10
                    end else if (ctr_dn_m) begin
                        out_ff <= 1'b0;
                    end
                end
                default: out_ff <= 1'b0;
            endcase
        end
    end

    // Interrupt flags on rising match edges
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            match_d_ff <= 4'h0;
            flag_ff <= 4'h0;
        end else begin
            match_d_ff <= {of_m, ph_m, dc_m, pr_m};
            // Set wins over a write-one clear
            flag_ff <= (flag_ff & ~((wr_acc && paddr == OFS_FLAGS) ?
                pwdata[3:0] : 4'h0)) |
                ({of_m, ph_m, dc_m, pr_m} & ~match_d_ff); // RULE23
        end
    end

    // Pin and offset event outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pwm_out <= 1'b0;
            offset_event_out <= 1'b0;
        end else begin
            pwm_out <= out_ff ^ pol_ff; // RULE14
            offset_event_out <= tick && run_ff && of_m; // RULE25
        end
    end

    // Output level readback synchroniser
    pwo_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .din(out_ff),
        .dout(out_rd)
    );

    // Period length in standard mode is period plus one ticks
    a_std_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && run_ff && mode_ff != MODE_CTR && pr_m && active &&
         !(ofm_ff == OFM_RST && ofs_in)) |=> tmr_ff == CNT_RST)
        else $error("timer did not wrap at period"); // RULE3
    a_pin_polar: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 pwm_out == ($past(out_ff) ^ $past(pol_ff)))
        else $error("pin polarity wrong"); // RULE14
    a_disable_idle: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        !active |=> tmr_ff == CNT_RST && !out_ff)
        else $error("disabled module still runs"); // RULE13
    a_ctr_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (active && tick && run_ff && mode_ff == MODE_CTR && ctr_up_m)
        |=> out_ff)
        else $error("center set missed"); // RULE10
    a_one_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ofm_ff == OFM_ONE && per_evt && active) |=> !run_ff)
        else $error("one-shot did not stop"); // RULE17
    a_hold_sync: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ofm_ff == OFM_SYNC && !run_ff && $stable(tmr_ff) && active)
        |=> tmr_ff == $past(tmr_ff))
        else $error("slave counted before start"); // RULE16
    a_arm_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (arm_ff && per_evt) |=> !arm_ff && pr_ff == $past(pr_buf_ff))
        else $error("load did not happen"); // RULE22
    a_flag_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (pr_m && !match_d_ff[FL_PER]) |=> flag_ff[FL_PER])
        else $error("period flag not set"); // RULE23
endmodule : pwo_top

/* pkg/pwo_pkg.sv */
package pwo_pkg;
    // Mode field encodings
    localparam logic [1:0] MODE_STD = 2'h0;
    localparam logic [1:0] MODE_SET = 2'h1;
    localparam logic [1:0] MODE_TOG = 2'h2;
    localparam logic [1:0] MODE_CTR = 2'h3;
    // Offset mode encodings
    localparam logic [1:0] OFM_IND = 2'h0;
    localparam logic [1:0] OFM_SYNC = 2'h1;
    localparam logic [1:0] OFM_ONE = 2'h2;
    localparam logic [1:0] OFM_RST = 2'h3;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PHASE = 8'h04;
    localparam logic [7:0] OFS_DUTY = 8'h08;
    localparam logic [7:0] OFS_PERIOD = 8'h0C;
    localparam logic [7:0] OFS_OFFSET = 8'h10;
    localparam logic [7:0] OFS_TIMER = 8'h14;
    localparam logic [7:0] OFS_CLKSEL = 8'h18;
    localparam logic [7:0] OFS_LOAD = 8'h1C;
    localparam logic [7:0] OFS_FLAGS = 8'h20;
    localparam logic [7:0] OFS_GLOBAL = 8'h24;
    // Control field positions
    localparam int CTL_EN = 7;
    localparam int CTL_OUT = 5;
    localparam int CTL_POL = 4;
    localparam int CTL_MODE = 2;
    localparam int CTL_OFM = 8;
    localparam int CTL_OFO = 10;
    // Load control field positions
    localparam int LD_ARM = 0;
    // Flag positions
    localparam int FL_PER = 0;
    localparam int FL_DUTY = 1;
    localparam int FL_PH = 2;
    localparam int FL_OFS = 3;
    // Reset values
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [7:0] CLKSEL_RST = 8'h00;
    // Unmapped read value
    localparam logic [31:0] RD_NONE = 32'h0000_0000;
endpackage : pwo_pkg

/* rtl/pwo_sync.sv */
// Two-stage level synchroniser into the bus domain
module pwo_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_ff; // First stage, read only by second
    // Two flops in a row
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_ff <= din;
            dout <= meta_ff;
        end
    end
endmodule : pwo_sync

/* tb/pwo_load_model.sv */
// Load on the wave pin: measures high time, period and rising edges
module pwo_load_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pwm_pin,
    output logic [15:0] hi_len_ff,
    output logic [15:0] per_len_ff,
    output logic [15:0] rise_cnt_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pin_d_ff; // Pin one cycle back
    logic [15:0] hi_cnt_ff; // Cycles high so far
    logic [15:0] per_cnt_ff; // Cycles since last rise
    // Edge timing of the pin, in sys_clk cycles
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_d_ff <= 1'b0;
            hi_cnt_ff <= 16'h0000;
            per_cnt_ff <= 16'h0000;
            hi_len_ff <= 16'h0000;
            per_len_ff <= 16'h0000;
            rise_cnt_ff <= 16'h0000;
        end else begin
            pin_d_ff <= pwm_pin;
            if (pwm_pin && !pin_d_ff) begin
                // Rise closes a period
                per_len_ff <= per_cnt_ff;
                per_cnt_ff <= 16'h0001;
                hi_cnt_ff <= 16'h0001;
                rise_cnt_ff <= rise_cnt_ff + 16'h0001;
            end else begin
                per_cnt_ff <= per_cnt_ff + 16'h0001;
                if (pwm_pin) begin
                    hi_cnt_ff <= hi_cnt_ff + 16'h0001;
                end
            end
            // Fall closes the active time
            if (!pwm_pin && pin_d_ff) begin
                hi_len_ff <= hi_cnt_ff;
            end
        end
    end
endmodule : pwo_load_model

/* tb/pwm16_offset_sync_tb_top.sv */
// Register-level bench for the wave generator
module pwm16_offset_sync_tb_top import pwo_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst_n, pwm_clk_tick, master_offset_event;
    logic psel, penable, pwrite, pready, pslverr, pwm_out;
    logic offset_event_out, tick_on, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] hi_len, per_len, rise_cnt, r0;
    int err_count, total_checks, g;

    pwo_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .pwm_clk_tick(pwm_clk_tick), .master_offset_event(master_offset_event),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_out(pwm_out),
        .offset_event_out(offset_event_out));
    pwo_load_model u_load (.sys_clk(sys_clk), .rst_n(rst_n),
        .pwm_pin(pwm_out), .hi_len_ff(hi_len), .per_len_ff(per_len),
        .rise_cnt_ff(rise_cnt));

    // Free-running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Prescaled tick follows the gate
    always @(posedge sys_clk) begin
        pwm_clk_tick <= tick_on;
    end

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, seen,
                     exp);
        end
    endtask : chk
    // One bus transfer, held until ready is sampled
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            chk(32'h0, 32'h1, "no ready");
        end
    endtask : apb
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    // Buffered counts, then arm (loads at once while disabled)
    task automatic cfg(input logic [31:0] ph, input logic [31:0] dc,
                       input logic [31:0] pr);
        apb(1'b1, OFS_PHASE, ph);
        apb(1'b1, OFS_DUTY, dc);
        apb(1'b1, OFS_PERIOD, pr);
        apb(1'b1, OFS_OFFSET, 32'h0000_0004);
        apb(1'b1, OFS_LOAD, 32'h0000_0001);
    endtask : cfg
    // Control word builder
    function automatic logic [31:0] cw(input logic en, input logic [1:0] md,
                                       input logic [1:0] ofm);
        return (32'(en) << CTL_EN) | (32'(md) << CTL_MODE) |
               (32'(ofm) << CTL_OFM);
    endfunction : cw
    // Spacing between offset event pulses
    task automatic gap(output int gg);
        int n;
        n = 0;
        while (offset_event_out !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        gg = 0;
        do begin
            @(posedge sys_clk);
            gg++;
        end while (offset_event_out !== 1'b1 && gg < 100);
    endtask : gap
    task automatic pulse_master();
        master_offset_event <= 1'b1;
        @(posedge sys_clk);
        master_offset_event <= 1'b0;
    endtask : pulse_master
    // Verdict and end of run
    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, master_offset_event} = 5'h00;
        tick_on = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        err_count = 0;
        total_checks = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset values and unmapped place
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'(CTRL_RST), "ctrl reset");
        apb(1'b0, OFS_TIMER, 32'h0);
        chk(rd, 32'(CNT_RST), "timer reset");
        apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
        apb(1'b0, 8'hFC, 32'h0);
        chk(rd, RD_NONE, "unmapped");
        chk(32'(last_err), 32'h0, "slverr");
        // Inversion while disabled
        apb(1'b1, OFS_CTRL, 32'h1 << CTL_POL);
        cyc(3);
        chk(32'(pwm_out), 32'h1, "pol idle");
        apb(1'b1, OFS_CTRL, 32'h0);
        // Standard, independent run
        cfg(32'h2, 32'h6, 32'h9);
        apb(1'b1, OFS_CTRL, cw(1'b1, MODE_STD, OFM_IND));
        cyc(60);
        chk(32'(per_len), 32'd10, "std period");
        chk(32'(hi_len), 32'd4, "std high");
        gap(g);
        chk(32'(g), 32'd10, "offset spacing");
        apb(1'b0, OFS_FLAGS, 32'h0);
        chk(rd, 32'hF, "flags");
        // Count writes wait for the arm
        apb(1'b1, OFS_PERIOD, 32'd19);
        cyc(60);
        chk(32'(per_len), 32'd10, "unarmed period");
        apb(1'b1, OFS_LOAD, 32'h1);
        cyc(80);
        chk(32'(per_len), 32'd20, "armed period");
        apb(1'b0, OFS_LOAD, 32'h0);
        chk(rd, 32'h0, "arm self clear");
        // Global mirror enable alone
        apb(1'b1, OFS_CTRL, cw(1'b0, MODE_STD, OFM_IND));
        apb(1'b1, OFS_GLOBAL, 32'h1);
        r0 = rise_cnt;
        cyc(80);
        chk(32'(per_len), 32'd20, "mirror run");
        chk(32'(rise_cnt - r0 >= 16'd3), 32'h1, "mirror rises");
        apb(1'b1, OFS_GLOBAL, 32'h0);
        apb(1'b1, OFS_FLAGS, 32'hF);
        apb(1'b0, OFS_FLAGS, 32'h0);
        chk(rd, 32'h0, "flags cleared");
        // Toggle, with an ignored output bit
        cfg(32'h2, 32'h6, 32'h9);
        apb(1'b1, OFS_CTRL, cw(1'b1, MODE_TOG, OFM_IND) | (32'h1 << CTL_OUT));
        cyc(100);
        chk(32'(per_len), 32'd20, "tog period");
        chk(32'(hi_len), 32'd10, "tog high");
        // Center aligned
        apb(1'b1, OFS_CTRL, 32'h0);
        cfg(32'h2, 32'h3, 32'h8);
        apb(1'b1, OFS_CTRL, cw(1'b1, MODE_CTR, OFM_IND) | (32'h1 << CTL_OUT));
        cyc(100);
        chk(32'(per_len), 32'd18, "ctr period");
        chk(32'(hi_len), 32'd6, "ctr high");
        // Set on match, cleared by software on a tick
        apb(1'b1, OFS_CTRL, 32'h0);
        cfg(32'h3, 32'h6, 32'h9);
        apb(1'b1, OFS_CTRL, cw(1'b1, MODE_SET, OFM_IND));
        cyc(40);
        chk(32'(pwm_out), 32'h1, "set active");
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(32'(rd[CTL_OUT]), 32'h1, "out readback");
        tick_on <= 1'b0;
        cyc(3);
        apb(1'b1, OFS_CTRL, cw(1'b1, MODE_SET, OFM_IND));
        cyc(5);
        chk(32'(pwm_out), 32'h1, "held until tick");
        tick_on <= 1'b1;
        @(posedge sys_clk);
        tick_on <= 1'b0;
        cyc(4);
        chk(32'(pwm_out), 32'h0, "cleared on tick");
        tick_on <= 1'b1;
        cyc(30);
        apb(1'b1, OFS_CTRL, 32'h0);
        cyc(4);
        chk(32'(pwm_out), 32'h0, "disable clears");
        // Sync start waits for the master event
        cfg(32'h2, 32'h6, 32'h9);
        apb(1'b1, OFS_CTRL, cw(1'b1, MODE_STD, OFM_SYNC));
        r0 = rise_cnt;
        cyc(40);
        chk(32'(rise_cnt), 32'(r0), "sync hold");
        pulse_master();
        cyc(40);
        chk(32'(rise_cnt - r0 >= 16'd3), 32'h1, "sync run");
        // One-shot; slave period kept apart from the master's
        apb(1'b1, OFS_CTRL, 32'h0);
        cfg(32'h2, 32'h6, 32'd13);
        apb(1'b1, OFS_CTRL, cw(1'b1, MODE_STD, OFM_ONE));
        pulse_master();
        cyc(40);
        r0 = rise_cnt;
        pulse_master();
        cyc(3);
        pulse_master();
        cyc(40);
        chk(32'(rise_cnt - r0), 32'h1, "one shot");
        apb(1'b0, OFS_TIMER, 32'h0);
        chk(rd, 32'h0, "stopped at zero");
        // Timer reset mode: hold, start, then restart at one
        apb(1'b1, OFS_CTRL, 32'h0);
        cfg(32'h2, 32'h6, 32'h9);
        apb(1'b1, OFS_CTRL, cw(1'b1, MODE_STD, OFM_RST));
        cyc(20);
        apb(1'b0, OFS_TIMER, 32'h0);
        chk(rd, 32'h0, "reset mode hold");
        pulse_master();
        cyc(5);
        pulse_master();
        apb(1'b0, OFS_TIMER, 32'h0);
        chk(rd, 32'h2, "reset mode restart");
        tally_and_finish();
    end
endmodule : pwm16_offset_sync_tb_top
